// file: hdl/oaf_shelf.sv
// station shelf outside address screening, repeat keying and wire forwarding
`timescale 1ns/1ps
module oaf_shelf
    import oaf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] receive_match_switch,
    input  wire logic [7:0] repeat_transmit_address_switch,
    input  wire logic [7:0] station_config_switch,
    input  wire logic       rf_rx_carrier,
    input  wire logic       rf_rx_bit,
    input  wire logic       rf_rx_bit_stb,
    input  wire logic       wire_rx_guarded,
    input  wire logic [7:0] wire_rx_address,
    input  wire logic       wire_rx_clear_key,
    input  wire logic       clear_monitor_req,
    input  wire logic       guarded_monitor_req,
    input  wire logic       local_tx_cmd,
    input  wire logic       remote_tx_cmd,
    output logic            repeater_key,
    output logic            wire_send,
    output logic [7:0]      rf_tx_address,
    output logic            rf_tx_from_wire,
    output logic [7:0]      wire_tx_address,
    output logic            tone_squelch_disable,
    output logic            guarded_monitor_active,
    output logic            rf_data_invert,
    output logic            wire_data_invert,
    output logic            rx_rejected
);
    typedef enum logic [1:0] {
        OAF_IDLE,
        OAF_ACTIVE,
        OAF_PREEMPT,
        OAF_WIRE_TX
    } oaf_state_t;

    // two-flop synchronisers for every pin input
    localparam int PIN_W = 24 + 1 + 1 + 1 + 1 + 8 + 1 + 1 + 1 + 1 + 1;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;

    assign pin_raw = {receive_match_switch, repeat_transmit_address_switch,
                      station_config_switch, rf_rx_carrier, rf_rx_bit, rf_rx_bit_stb,
                      wire_rx_guarded, wire_rx_address, wire_rx_clear_key,
                      clear_monitor_req, guarded_monitor_req, local_tx_cmd,
                      remote_tx_cmd};

    // pins pass two flip-flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // synchronised copies, named by use
    logic [7:0] s_match;
    logic [7:0] s_txsw;
    logic [7:0] s_cfg;
    logic       s_carrier;
    logic       s_bit;
    logic       s_stb;
    logic       s_wguard;
    logic [7:0] s_waddr;
    logic       s_wclear;
    logic       s_cmon;
    logic       s_gmon;
    logic       s_console;

    assign s_match   = pin_s2[PIN_W-1 -: 8];
    assign s_txsw    = pin_s2[PIN_W-9 -: 8];
    assign s_cfg     = pin_s2[PIN_W-17 -: 8];
    assign s_carrier = pin_s2[16];
    assign s_bit     = pin_s2[15];
    assign s_stb     = pin_s2[14];
    assign s_wguard  = pin_s2[13];
    assign s_waddr   = pin_s2[12:5];
    assign s_wclear  = pin_s2[4];
    assign s_cmon    = pin_s2[3];
    assign s_gmon    = pin_s2[2];
    assign s_console = pin_s2[1] | pin_s2[0];

    // configuration bank decode
    oaf_mode_t mode;
    logic      has_repeat;
    logic      has_wire;

    assign mode       = oaf_mode_t'(s_cfg[CFG_MODE_LO +: 2]);
    assign has_repeat = (mode != OAF_MODE_REMOTE);
    assign has_wire   = (mode != OAF_MODE_REPEAT);

    // edge detection on synchronised request lines
    logic prev_stb, next_prev_stb;
    logic prev_cmon, next_prev_cmon;
    logic prev_gmon, next_prev_gmon;
    logic prev_wclr, next_prev_wclr;
    logic prev_wgrd, next_prev_wgrd;
    logic stb_rise, cmon_rise, gmon_rise, wclr_rise, wgrd_rise;

    always_comb begin
        next_prev_stb  = s_stb;
        next_prev_cmon = s_cmon;
        next_prev_gmon = s_gmon;
        next_prev_wclr = s_wclear;
        next_prev_wgrd = s_wguard;
        stb_rise       = s_stb & ~prev_stb;
        cmon_rise      = s_cmon & ~prev_cmon;
        gmon_rise      = s_gmon & ~prev_gmon;
        wclr_rise      = s_wclear & ~prev_wclr;
        wgrd_rise      = s_wguard & ~prev_wgrd;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_stb  <= 1'b0;
            prev_cmon <= 1'b0;
            prev_gmon <= 1'b0;
            prev_wclr <= 1'b0;
            prev_wgrd <= 1'b0;
        end else begin
            prev_stb  <= next_prev_stb;
            prev_cmon <= next_prev_cmon;
            prev_gmon <= next_prev_gmon;
            prev_wclr <= next_prev_wclr;
            prev_wgrd <= next_prev_wgrd;
        end
    end

    // monitor overrides; a new request wins over a clear in the same cycle
    logic next_cmon_act;
    logic next_gmon_act;

    always_comb begin
        next_cmon_act = tone_squelch_disable;
        next_gmon_act = guarded_monitor_active;
        if (wclr_rise) begin
            next_cmon_act = 1'b0;
            next_gmon_act = 1'b0;
        end
        if (cmon_rise)
            next_cmon_act = 1'b1;
        if (gmon_rise)
            next_gmon_act = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tone_squelch_disable   <= 1'b0;
            guarded_monitor_active <= 1'b0;
        end else begin
            tone_squelch_disable   <= next_cmon_act;
            guarded_monitor_active <= next_gmon_act;
        end
    end

    // received bit stream, inverted when the RF path asks for it
    oaf_addr_if ah ();
    logic       rx_bit_fixed;

    assign rx_bit_fixed = s_bit ^ s_cfg[CFG_RF_INV];
    assign ah.carrier   = s_carrier;

    oaf_sync_hunter u_hunter (
        .clk     (clk),
        .rst     (rst),
        .bit_in  (rx_bit_fixed),
        .bit_stb (stb_rise),
        .ah      (ah)
    );

    logic       j_done;
    logic       j_accept;
    logic [7:0] j_rep;
    logic [7:0] j_wire;

    oaf_addr_judge u_judge (
        .clk         (clk),
        .rst         (rst),
        .ah          (ah),
        .match_addr  (s_match),
        .repeat_addr (s_txsw),
        .all_call_en (s_cfg[CFG_ALL_CALL]),
        .remote_only (mode == OAF_MODE_REMOTE),
        .monitor     (guarded_monitor_active),
        .done        (j_done),
        .accept      (j_accept),
        .rep_out     (j_rep),
        .wire_out    (j_wire)
    );

    // main control: repeat or forward, with console preemption
    oaf_state_t state, next_state;
    logic       next_rkey;
    logic       next_wsend;
    logic [7:0] next_rf_addr;
    logic       next_from_wire;
    logic [7:0] next_wire_addr;
    logic       next_rejected;

    always_comb begin
        next_state     = state;
        next_rf_addr   = rf_tx_address;
        next_from_wire = rf_tx_from_wire;
        next_wire_addr = wire_tx_address;
        next_rejected  = 1'b0;
        case (state)
            OAF_IDLE: begin
                if (s_console) begin
                    next_state = OAF_PREEMPT;
                end else if (wgrd_rise && has_wire) begin
                    next_state     = OAF_WIRE_TX;
                    next_rf_addr   = s_waddr;
                    next_from_wire = 1'b1;
                end else if (j_done && j_accept && s_carrier) begin
                    next_state     = OAF_ACTIVE;
                    next_rf_addr   = j_rep;
                    next_wire_addr = j_wire;
                    next_from_wire = 1'b0;
                end else if (j_done) begin
                    next_rejected = 1'b1;
                end
            end
            OAF_ACTIVE: begin
                if (s_console)
                    next_state = OAF_PREEMPT;
                else if (!s_carrier)
                    next_state = OAF_IDLE;
                else if (j_done && !j_accept) begin
                    next_state    = OAF_IDLE;
                    next_rejected = 1'b1;
                end else if (j_done) begin
                    next_rf_addr   = j_rep;
                    next_wire_addr = j_wire;
                end
            end
            OAF_PREEMPT: begin
                if (!s_console)
                    next_state = OAF_IDLE;
            end
            OAF_WIRE_TX: begin
                if (s_console)
                    next_state = OAF_PREEMPT;
                else if (!s_wguard)
                    next_state = OAF_IDLE;
                else if (wgrd_rise)
                    next_rf_addr = s_waddr;
            end
            default: next_state = OAF_IDLE;
        endcase
        next_rkey  = (next_state == OAF_ACTIVE) && has_repeat;
        next_wsend = (next_state == OAF_ACTIVE) && has_wire;
        // wire origin flag stands only while the wire signal is being sent on
        next_from_wire = (next_state == OAF_WIRE_TX);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state           <= OAF_IDLE;
            repeater_key    <= 1'b0;
            wire_send       <= 1'b0;
            rf_tx_address   <= 8'h00;
            rf_tx_from_wire <= 1'b0;
            wire_tx_address <= 8'h00;
            rx_rejected     <= 1'b0;
        end else begin
            state           <= next_state;
            repeater_key    <= next_rkey;
            wire_send       <= next_wsend;
            rf_tx_address   <= next_rf_addr;
            rf_tx_from_wire <= next_from_wire;
            wire_tx_address <= next_wire_addr;
            rx_rejected     <= next_rejected;
        end
    end

    // data inversion flags for the downstream paths
    always_ff @(posedge clk) begin
        if (rst) begin
            rf_data_invert   <= 1'b0;
            wire_data_invert <= 1'b0;
        end else begin
            rf_data_invert   <= s_cfg[CFG_RF_INV];
            wire_data_invert <= s_cfg[CFG_WIRE_INV];
        end
    end
endmodule

// file: hdl/oaf_pkg.sv
// shared constants for the outside address filter and repeater shelf logic
// Functional notes
// - outside address is 8 bits following each sync word; AC means all-call
// - three switch banks: receive match, repeat transmit address, configuration
// - RF signal must match receive address before keying repeater or wire send
// - receive address AC accepts all, passing received address unchanged on both paths
// - repeat modes insert transmit switch address unless receive address is AC
// - remote modes transmit on RF the address received from the wire line
// - non-AC match repeats with transmit switch address; wire keeps received address
// - all-call decode enabled accepts AC; repeats transmit switch address, wire gets AC
// - all-call decode disabled ignores non-matching addresses including AC; the judge still accepts AC in remote mode
// - configuration bank selects mode, RF and wire inversion, all-call decode enable
// - clear-mode monitor request disables receive tone squelch
// - guarded monitor acts as receive AC; wire unchanged, repeat with switch address
// - clear-mode wire keying clears monitor override, restoring normal operation
// - local or remote console transmit preempts repeating at once
// - remote-only station accepts all-call as well as its programmed address
package oaf_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ALL_CALL_ADDR = 8'hac;
    // configuration bank fields
    localparam int          CFG_MODE_LO   = 0;
    localparam int          CFG_RF_INV    = 2;
    localparam int          CFG_WIRE_INV  = 3;
    localparam int          CFG_ALL_CALL  = 4;
    localparam logic [7:0]  SWITCH_RESET  = 8'h00;
    // sync word pattern; arbitrary neutral value
    localparam int          SYNC_W        = 16;
    localparam logic [15:0] SYNC_PATTERN  = 16'h5a3c;

    typedef enum logic [1:0] {
        OAF_MODE_REMOTE,
        OAF_MODE_REPEAT,
        OAF_MODE_REMOTE_REPEAT,
        OAF_MODE_VOTED
    } oaf_mode_t;

    // exact 8-bit equality of two addresses
    function automatic logic oaf_addr_eq(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction
endpackage

// file: hdl/oaf_addr_if.sv
// carrier for the address caught after a sync word
`timescale 1ns/1ps
interface oaf_addr_if;
    logic       addr_valid;
    logic [7:0] address;
    logic       carrier;

    modport hunter (
        output addr_valid,
        output address,
        input  carrier
    );
    modport judge (
        input addr_valid,
        input address,
        input carrier
    );
endinterface

// file: hdl/oaf_sync_hunter.sv
// finds the sync word in the received bit stream and captures the address
`timescale 1ns/1ps
module oaf_sync_hunter
    import oaf_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   bit_in,
    input  wire logic   bit_stb,
    oaf_addr_if.hunter  ah
);
    typedef enum logic {OAF_HUNT, OAF_ADDR} oaf_hunt_t;

    oaf_hunt_t         state, next_state;
    logic [SYNC_W-1:0] sr, next_sr;
    logic [2:0]        cnt, next_cnt;
    logic [7:0]        addr, next_addr;
    logic              vld, next_vld;
    logic [SYNC_W-1:0] shifted;

    // hunt for sync, then gather eight address bits msb first
    always_comb begin
        shifted    = {sr[SYNC_W-2:0], bit_in};
        next_state = state;
        next_sr    = sr;
        next_cnt   = cnt;
        next_addr  = addr;
        next_vld   = 1'b0;
        if (!ah.carrier) begin
            next_state = OAF_HUNT;
            next_cnt   = 3'd0;
        end else if (bit_stb) begin
            case (state)
                OAF_HUNT: begin
                    next_sr = shifted;
                    if (shifted == SYNC_PATTERN) begin
                        next_state = OAF_ADDR;
                        next_cnt   = 3'd0;
                    end
                end
                OAF_ADDR: begin
                    next_addr = {addr[6:0], bit_in};
                    next_cnt  = cnt + 3'd1;
                    if (cnt == 3'd7) begin
                        next_vld   = 1'b1;
                        next_state = OAF_HUNT;
                        next_sr    = '0;
                    end
                end
                default: next_state = OAF_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= OAF_HUNT;
            sr    <= '0;
            cnt   <= 3'd0;
            addr  <= 8'h00;
            vld   <= 1'b0;
        end else begin
            state <= next_state;
            sr    <= next_sr;
            cnt   <= next_cnt;
            addr  <= next_addr;
            vld   <= next_vld;
        end
    end

    assign ah.addr_valid = vld;
    assign ah.address    = addr;
endmodule

// file: hdl/oaf_addr_judge.sv
// decides acceptance of a received address and the addresses to send on
`timescale 1ns/1ps
module oaf_addr_judge
    import oaf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    oaf_addr_if.judge        ah,
    input  wire logic [7:0]  match_addr,
    input  wire logic [7:0]  repeat_addr,
    input  wire logic        all_call_en,
    input  wire logic        remote_only,
    input  wire logic        monitor,
    output logic             done,
    output logic             accept,
    output logic [7:0]       rep_out,
    output logic [7:0]       wire_out
);
    logic       next_done, next_accept;
    logic [7:0] next_rep, next_wire;
    logic       any_addr, is_ac;

    // judge one captured address
    always_comb begin
        any_addr    = oaf_addr_eq(match_addr, ALL_CALL_ADDR) || monitor;
        is_ac       = oaf_addr_eq(ah.address, ALL_CALL_ADDR);
        next_done   = ah.addr_valid;
        next_accept = accept;
        next_rep    = rep_out;
        next_wire   = wire_out;
        if (ah.addr_valid) begin
            next_accept = any_addr
                || oaf_addr_eq(ah.address, match_addr)
                || (is_ac && (all_call_en || remote_only));
            next_wire = ah.address;
            if (oaf_addr_eq(match_addr, ALL_CALL_ADDR) && !monitor)
                next_rep = ah.address;
            else
                next_rep = repeat_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done     <= 1'b0;
            accept   <= 1'b0;
            rep_out  <= 8'h00;
            wire_out <= 8'h00;
        end else begin
            done     <= next_done;
            accept   <= next_accept;
            rep_out  <= next_rep;
            wire_out <= next_wire;
        end
    end
endmodule

// file: verification/oaf_shelf_assertions.sv
// checker on the shelf ports for screening, keying and monitor behaviour
`timescale 1ns/1ps
module oaf_shelf_chk
    import oaf_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] station_config_switch,
    input wire logic       rf_rx_carrier,
    input wire logic       wire_rx_guarded,
    input wire logic [7:0] wire_rx_address,
    input wire logic       wire_rx_clear_key,
    input wire logic       clear_monitor_req,
    input wire logic       guarded_monitor_req,
    input wire logic       local_tx_cmd,
    input wire logic       remote_tx_cmd,
    input wire logic       repeater_key,
    input wire logic       wire_send,
    input wire logic [7:0] rf_tx_address,
    input wire logic       rf_tx_from_wire,
    input wire logic       tone_squelch_disable,
    input wire logic       guarded_monitor_active,
    input wire logic       rf_data_invert,
    input wire logic       wire_data_invert,
    input wire logic       rx_rejected
);
    logic [2:0] up;
    logic [2:0] next_up;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since reset, so edge detectors never see pre-reset values
    always_comb begin
        next_up = (up == 3'h7) ? up : up + 3'h1;
    end
    always_ff @(posedge clk) begin
        up <= rst ? 3'h0 : next_up;
    end
    // request steps seen at the pins
    sequence s_mon_req;
        up == 3'h7 && $rose(guarded_monitor_req);
    endsequence
    sequence s_sq_req;
        up == 3'h7 && $rose(clear_monitor_req);
    endsequence
    sequence s_clear_key;
        up == 3'h7 && $rose(wire_rx_clear_key) && !clear_monitor_req && !guarded_monitor_req;
    endsequence
    sequence s_wire_take;
        up == 3'h7 && $rose(wire_rx_guarded) && !rf_rx_carrier && !local_tx_cmd
            && !remote_tx_cmd && station_config_switch[1:0] == 2'h0;
    endsequence
    rej_drops_keys_a: assert property (rx_rejected |=> !repeater_key && !wire_send)
        else $error("keys high after a rejected address");
    rej_pulse_a: assert property (rx_rejected |=> !rx_rejected)
        else $error("reject flag longer than one cycle");
    remote_no_key_a: assert property ((station_config_switch[1:0] == 2'h0)[*5] |-> !repeater_key)
        else $error("repeater keyed in remote mode");
    repeat_no_wire_a: assert property ((station_config_switch[1:0] == 2'h1)[*5] |-> !wire_send)
        else $error("wire send in repeat mode");
    invert_copy_a: assert property (up == 3'h7 && $stable(station_config_switch)[*5] |->
        rf_data_invert == station_config_switch[2] && wire_data_invert == station_config_switch[3])
        else $error("inversion outputs differ from configuration");
    preempt_a: assert property ((local_tx_cmd || remote_tx_cmd)[*6] |-> !repeater_key && !wire_send)
        else $error("console command did not preempt");
    carrier_drop_a: assert property ((!rf_rx_carrier)[*6] |-> !repeater_key && !wire_send)
        else $error("keys held without carrier");
    mon_set_a: assert property (s_mon_req |-> ##[1:6] guarded_monitor_active)
        else $error("guarded monitor not set");
    squelch_set_a: assert property (s_sq_req |-> ##[1:6] tone_squelch_disable)
        else $error("tone squelch not disabled");
    mon_clear_a: assert property (s_clear_key |-> ##[1:6] !tone_squelch_disable && !guarded_monitor_active)
        else $error("monitors not cleared");
    wire_addr_a: assert property (s_wire_take |-> ##[2:8] rf_tx_from_wire && rf_tx_address == wire_rx_address)
        else $error("wire address not sent on radio");
endmodule

bind oaf_shelf oaf_shelf_chk oaf_shelf_chk_i (
    .clk, .rst, .station_config_switch, .rf_rx_carrier, .wire_rx_guarded, .wire_rx_address,
    .wire_rx_clear_key, .clear_monitor_req, .guarded_monitor_req, .local_tx_cmd,
    .remote_tx_cmd, .repeater_key, .wire_send, .rf_tx_address, .rf_tx_from_wire,
    .tone_squelch_disable, .guarded_monitor_active, .rf_data_invert, .wire_data_invert,
    .rx_rejected
);

// file: verification/oaf_rf_model.sv
// behavioural radio receiver side: sends guarded frames toward the shelf
`timescale 1ns/1ps
module oaf_rf_model
    import oaf_pkg::*;
(
    input  wire logic clk,
    output logic      carrier,
    output logic      rx_bit,
    output logic      rx_stb
);
    // strobe stands still outside frames
    initial begin
        carrier = 1'b0;
        rx_bit  = 1'b0;
        rx_stb  = 1'b0;
    end
    // sync word then 8 address bits, msb first; returns at the last strobe rise
    task automatic frame(input logic [7:0] a, input logic inv, input int gap);
        logic [23:0] w;
        w = {SYNC_PATTERN, a};
        @(posedge clk);
        carrier <= 1'b1;
        for (int i = 23; i >= 0; i--) begin
            repeat (gap) @(posedge clk);
            rx_stb <= 1'b0;
            rx_bit <= w[i] ^ inv;
            repeat (gap) @(posedge clk);
            rx_stb <= 1'b1;
        end
    endtask
    // end of frame: carrier off, data line no longer holds its last value
    task automatic drop(input int gap);
        repeat (gap) @(posedge clk);
        rx_stb  <= 1'b0;
        carrier <= 1'b0;
        rx_bit  <= ~rx_bit;
    endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the outside address shelf logic
`timescale 1ns/1ps
module testbench;
    import oaf_pkg::*;
    logic       clk, rst, rf_rx_carrier, rf_rx_bit, rf_rx_bit_stb, wire_rx_guarded;
    logic [7:0] match, rep, cfg, wire_rx_address, rf_tx_address, wire_tx_address;
    logic [2:0] req;
    logic [1:0] tx;
    logic       repeater_key, wire_send, rf_tx_from_wire, tone_squelch_disable;
    logic       guarded_monitor_active, rf_data_invert, wire_data_invert, rx_rejected;
    wire  [5:0] fl = {rf_tx_from_wire, tone_squelch_disable, guarded_monitor_active,
                      rx_rejected, wire_send, repeater_key};
    int         mismatches, checks;

    oaf_shelf oaf_shelf_i (
        .clk, .rst, .receive_match_switch(match), .repeat_transmit_address_switch(rep),
        .station_config_switch(cfg), .rf_rx_carrier, .rf_rx_bit, .rf_rx_bit_stb,
        .wire_rx_guarded, .wire_rx_address, .wire_rx_clear_key(req[2]),
        .clear_monitor_req(req[0]), .guarded_monitor_req(req[1]), .local_tx_cmd(tx[0]),
        .remote_tx_cmd(tx[1]), .repeater_key, .wire_send, .rf_tx_address, .rf_tx_from_wire,
        .wire_tx_address, .tone_squelch_disable, .guarded_monitor_active, .rf_data_invert,
        .wire_data_invert, .rx_rejected
    );
    oaf_rf_model oaf_rf_model_i (.clk, .carrier(rf_rx_carrier), .rx_bit(rf_rx_bit),
        .rx_stb(rf_rx_bit_stb));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // compare one value and count it
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bounded wait until the masked flags reach the wanted or-level
    task automatic wait_fl(input logic [5:0] m, input logic v);
        int n;
        n = 0;
        while ((|(fl & m)) !== v && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 60) begin
            chk("wait for flags", 8'(m), 8'h00);
            end_of_test();
        end
    endtask
    // set the switch banks and let them settle
    task automatic setup(input logic [7:0] c, input logic [7:0] m);
        @(posedge clk);
        cfg   <= c;
        match <= m;
        repeat (6) @(posedge clk);
    endtask
    // one received frame and its judged outcome
    task automatic rx(input logic [7:0] a, input logic acc, input logic [7:0] rf,
                      input logic [7:0] wa, input int gap);
        oaf_rf_model_i.frame(a, cfg[2], gap);
        wait_fl(acc ? 6'h03 : 6'h04, 1'b1);
        chk("rejected", 8'(!acc), 8'(rx_rejected));
        chk("key", 8'(acc && cfg[1:0] != 2'h0), 8'(repeater_key));
        chk("send", 8'(acc && cfg[1:0] != 2'h1), 8'(wire_send));
        if (acc) begin
            chk("wire addr", wa, wire_tx_address);
            if (cfg[1:0] != 2'h0) chk("rf addr", rf, rf_tx_address);
        end
    endtask
    task automatic idle();
        oaf_rf_model_i.drop(4);
        wait_fl(6'h03, 1'b0);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        req[k] <= 1'b1;
        repeat (4) @(posedge clk);
        req[k] <= 1'b0;
    endtask

    task automatic t_reset();
        chk("outputs at reset", 8'h00, 8'(fl) | rf_tx_address | wire_tx_address);
        setup(8'h0c, 8'h3a);
        chk("invert", 8'h03, 8'({rf_data_invert, wire_data_invert}));
        setup(8'h04, 8'h3a);
        chk("invert", 8'h02, 8'({rf_data_invert, wire_data_invert}));
        $display("test reset done");
    endtask
    task automatic t_match();
        setup(8'h06, 8'h3a);
        rx(8'h3a, 1'b1, 8'h71, 8'h3a, 4);
        rx(8'h3b, 1'b0, 8'h00, 8'h00, 7);
        chk("keys after reject", 8'h00, 8'(fl[1:0]));
        idle();
        rx(ALL_CALL_ADDR, 1'b0, 8'h00, 8'h00, 4);
        idle();
        $display("test match done");
    endtask
    task automatic t_allcall();
        setup(8'h12, 8'h3a);
        rx(ALL_CALL_ADDR, 1'b1, 8'h71, ALL_CALL_ADDR, 4);
        idle();
        setup(8'h02, ALL_CALL_ADDR);
        rx(8'h5e, 1'b1, 8'h5e, 8'h5e, 4);
        idle();
        $display("test all-call done");
    endtask
    task automatic t_modes();
        for (int md = 0; md < 4; md++) begin
            setup(8'(md), 8'hff);
            rx(8'hff, 1'b1, 8'h71, 8'hff, 4);
            idle();
        end
        setup(8'h00, 8'h3a);
        rx(ALL_CALL_ADDR, 1'b1, 8'h71, ALL_CALL_ADDR, 4);
        idle();
        $display("test modes done");
    endtask
    task automatic t_monitor();
        setup(8'h02, 8'h3a);
        pulse(1);
        wait_fl(6'h08, 1'b1);
        rx(8'h44, 1'b1, 8'h71, 8'h44, 4);
        idle();
        pulse(0);
        wait_fl(6'h10, 1'b1);
        pulse(2);
        wait_fl(6'h18, 1'b0);
        rx(8'h44, 1'b0, 8'h00, 8'h00, 4);
        idle();
        $display("test monitor done");
    endtask
    task automatic t_wire();
        setup(8'h00, 8'h3a);
        wire_rx_address <= 8'h99;
        wire_rx_guarded <= 1'b1;
        wait_fl(6'h20, 1'b1);
        chk("rf from wire", 8'h99, rf_tx_address);
        @(posedge clk);
        wire_rx_guarded <= 1'b0;
        wait_fl(6'h20, 1'b0);
        setup(8'h01, 8'h3a);
        wire_rx_address <= 8'h66;
        wire_rx_guarded <= 1'b1;
        repeat (10) @(posedge clk);
        chk("wire refused in repeat", 8'h00, 8'(rf_tx_from_wire));
        wire_rx_guarded <= 1'b0;
        $display("test wire done");
    endtask
    task automatic t_preempt();
        setup(8'h02, 8'h3a);
        for (int k = 0; k < 2; k++) begin
            rx(8'h3a, 1'b1, 8'h71, 8'h3a, 4);
            @(posedge clk);
            tx[k] <= 1'b1;
            wait_fl(6'h03, 1'b0);
            repeat (6) @(posedge clk);
            chk("keys under console", 8'h00, 8'(fl[1:0]));
            tx[k] <= 1'b0;
            idle();
        end
        $display("test preempt done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = 3'h0;
        tx = 2'h0;
        match = 8'h00;
        rep = 8'h71;
        cfg = 8'h00;
        wire_rx_guarded = 1'b0;
        wire_rx_address = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_match();
        t_allcall();
        t_modes();
        t_monitor();
        t_wire();
        t_preempt();
        end_of_test();
    end
endmodule
